/* File: core/dbsp_device.sv */
// module: sram end of the burst-of-two double-data-rate port
// Notes on behaviour
// R1 - controller runs clocks 20 us before access
// R2 - controller holds loop bypass high normally; here always low, the 10 MHz link being below 120 MHz
// R3 - bypass low skips loop, setup still needed
// R4 - loop needs link clock of 120 MHz
// R5 - clock or bypass change repeats stabilisation
// R6 - read valid rises half cycle early
// R7 - read valid falls half cycle early
// R8 - read valid moves with echo clock edges
// R9 - termination on receiving, off while driving
// R10 - termination select picks low/high range
// R11 - termination off at read plus 2.0
// R12 - termination on at read plus 3.5
// R13 - termination edges follow echo clock edges
// R14 - write beats at next rise and fall
// R15 - read words at fall t+2, rise t+3
// R16 - commands sampled on link rise only
// R17 - write data on both edges, read out
// R18 - data bus released from power-up
// R19 - stop clocks parked at opposite levels
// R20 - second word flips lowest address bit
// R21 - low byte enable writes its lane
// R22 - burst is exactly two words
// R23 - load high means no operation
`timescale 1ns/1ps
module dbsp_device
    import dbsp_pkg::*;
(
    dbsp_link_if.dev    link,
    input  wire logic   reset,
    output logic        loop_ready,
    output logic        term_enable,
    output logic        term_high_range
);
    // ======================================================
    // storage
    // the full array is kept; a simulator allocates it once
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // ======================================================
    // pin synchronisers and loop settling
    logic              bypass_s1_reg;
    logic              bypass_s2_reg;
    logic              bypass_prev_reg;
    logic              tsel_s1_reg;
    logic              tsel_s2_reg;
    logic [STAB_W-1:0] stab_cnt_reg;
    logic              loop_ready_reg;
    logic              term_high_reg;

    // static pins from the far domain pass two flops first
    always_ff @(posedge link.link_clk)
    begin
        if (reset)
        begin
            bypass_s1_reg <= 1'b0;
            bypass_s2_reg <= 1'b0;
            tsel_s1_reg   <= 1'b1;
            tsel_s2_reg   <= 1'b1;
        end
        else
        begin
            bypass_s1_reg <= link.loop_bypass_n;
            bypass_s2_reg <= bypass_s1_reg;
            tsel_s1_reg   <= link.termination_select;
            tsel_s2_reg   <= tsel_s1_reg;
        end
    end

    // low selects the 0.3 range, high or floating the 0.6 range
    always_ff @(posedge link.link_clk)
    begin
        if (reset)
            term_high_reg <= 1'b1;
        else
            term_high_reg <= tsel_s2_reg;  // R10
    end

    // settle count restarts on reset or any bypass change; the
    // bypassed loop still waits out the setup stage
    always_ff @(posedge link.link_clk)
    begin
        if (reset || (bypass_s2_reg != bypass_prev_reg))
        begin
            stab_cnt_reg   <= '0;  // R5
            loop_ready_reg <= 1'b0;  // R3
        end
        else if (stab_cnt_reg == STAB_W'(STAB_LINK_CYCLES - 1))
            loop_ready_reg <= 1'b1;
        else
            stab_cnt_reg <= stab_cnt_reg + STAB_W'(1);
    end

    always_ff @(posedge link.link_clk)
    begin
        if (reset)
            bypass_prev_reg <= 1'b0;
        else
            bypass_prev_reg <= bypass_s2_reg;
    end

    // ======================================================
    // command pipeline on the link rise
    logic              rd1_reg;
    logic              rd2_reg;
    logic              rd3_reg;
    logic [ADDR_W-1:0] ra1_reg;
    logic [ADDR_W-1:0] ra2_reg;
    logic [ADDR_W-1:0] ra3_reg;
    logic              wr1_reg;
    logic              wr2_reg;
    logic [ADDR_W-1:0] wa1_reg;
    logic [ADDR_W-1:0] wa2_reg;
    logic              cmd_read;
    logic              cmd_write;

    // strobe and direction only count at the rising edge
    assign cmd_read  = !link.load_strobe_n && link.read_not_write;  // R15
    assign cmd_write = !link.load_strobe_n && !link.read_not_write; // R14

    // a high strobe loads nothing: the pipeline just drains
    always_ff @(posedge link.link_clk)
    begin
        if (reset)
        begin
            rd1_reg <= 1'b0;
            rd2_reg <= 1'b0;
            rd3_reg <= 1'b0;
            wr1_reg <= 1'b0;
            wr2_reg <= 1'b0;
        end
        else
        begin
            rd1_reg <= cmd_read;  // R16
            rd2_reg <= rd1_reg;
            rd3_reg <= rd2_reg;
            wr1_reg <= cmd_write;  // R23
            wr2_reg <= wr1_reg;
        end
    end

    // addresses ride along; only a loaded command replaces them
    always_ff @(posedge link.link_clk)
    begin
        if (reset)
        begin
            ra1_reg <= '0;
            ra2_reg <= '0;
            ra3_reg <= '0;
            wa1_reg <= '0;
            wa2_reg <= '0;
        end
        else
        begin
            if (!link.load_strobe_n)
            begin
                ra1_reg <= link.sync_address;
                wa1_reg <= link.sync_address;
            end
            ra2_reg <= ra1_reg;
            ra3_reg <= ra2_reg;
            wa2_reg <= wa1_reg;
        end
    end

    // ======================================================
    // write beats: first on the rise, second on the fall
    logic [DATA_W-1:0] wd0_reg;
    logic [DATA_W-1:0] wd1_reg;
    logic [LANES-1:0]  be0_n_reg;
    logic [LANES-1:0]  be1_n_reg;

    always_ff @(posedge link.link_clk)
    begin
        if (reset)
        begin
            wd0_reg   <= '0;
            be0_n_reg <= '1;
        end
        else if (wr1_reg)
        begin
            wd0_reg   <= link.dq;  // R17
            be0_n_reg <= link.byte_write_enable_n;
        end
    end

    // enables may differ between beats, so each beat keeps its own
    always_ff @(negedge link.link_clk)
    begin
        if (reset)
        begin
            wd1_reg   <= '0;
            be1_n_reg <= '1;
        end
        else if (wr2_reg)
        begin
            wd1_reg   <= link.dq;  // R14
            be1_n_reg <= link.byte_write_enable_n;
        end
    end

    // both beats commit together one rise later; a read issued
    // right behind this write still sees the new words
    always_ff @(posedge link.link_clk)
    begin
        if (wr2_reg)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (!be0_n_reg[i])
                    mem[wa2_reg][i*LANE_W +: LANE_W] <=
                        wd0_reg[i*LANE_W +: LANE_W];  // R21
                if (!be1_n_reg[i])
                    mem[wa2_reg ^ BURST_FLIP][i*LANE_W +: LANE_W] <=
                        wd1_reg[i*LANE_W +: LANE_W];  // R20
            end
        end
    end

    // ======================================================
    // read return at latency 2.5
    logic [DATA_W-1:0] q_first_reg;
    logic [DATA_W-1:0] q_second_reg;
    logic              dq_oe_reg;
    logic              valid_reg;

    // first word and bus drive start on the fall two cycles on;
    // the enable drops on the fall after the second word
    always_ff @(negedge link.link_clk)
    begin
        if (reset)
        begin
            q_first_reg <= '0;
            dq_oe_reg   <= 1'b0;  // R18
        end
        else
        begin
            dq_oe_reg <= rd3_reg;  // R22
            if (rd3_reg)
                q_first_reg <= mem[ra3_reg];  // R15
        end
    end

    // second word from the flipped address on the following rise
    always_ff @(posedge link.link_clk)
    begin
        if (reset)
            q_second_reg <= '0;
        else if (rd3_reg)
            q_second_reg <= mem[ra3_reg ^ BURST_FLIP];  // R20
    end

    // valid leads the first word and the end of the last by half a cycle
    always_ff @(posedge link.link_clk)
    begin
        if (reset)
            valid_reg <= 1'b0;
        else
            valid_reg <= rd2_reg;  // R6 R7 R8
    end

    // ======================================================
    // pin drive
    // the clock level tells which half of the burst is on the bus
    assign link.dev_dq_out     = link.link_clk ? q_second_reg : q_first_reg;
    assign link.dev_dq_oe      = dq_oe_reg;  // R17
    assign link.echo_clock     = link.link_clk;
    assign link.echo_clock_n   = ~link.link_clk;
    assign link.read_valid_out = valid_reg;

    // valid covers rise t+2..t+3, enable fall t+2..t+3: their union
    // is exactly the window with termination off
    assign term_enable     = !(valid_reg || dq_oe_reg);  // R9 R11 R12 R13
    assign term_high_range = term_high_reg;
    assign loop_ready      = loop_ready_reg;
endmodule

/* File: core/dbsp_pkg.sv */
// package: shared constants of the burst-of-two sram port
package dbsp_pkg;
    // bus shape
    localparam int DATA_W = 36;
    localparam int ADDR_W = 20;
    localparam int LANE_W = 9;
    localparam int LANES  = 4;
    // second word of a burst flips the lowest address bit
    localparam logic [ADDR_W-1:0] BURST_FLIP = 20'h0_0001;

    // clocking: the link clock is the controller clock divided by four
    localparam int CLK_PERIOD_NS     = 25;
    localparam int CLK_FREQ_MHZ      = 40;
    localparam int LINK_DIV          = 4;
    localparam int LINK_PERIOD_NS    = CLK_PERIOD_NS * LINK_DIV;
    localparam int LINK_FREQ_MHZ     = CLK_FREQ_MHZ / LINK_DIV;
    localparam int LOOP_MIN_FREQ_MHZ = 120;
    localparam bit LOOP_FREQ_OK = (LINK_FREQ_MHZ >= LOOP_MIN_FREQ_MHZ);

    // clock stabilisation before the first access (least time: round up)
    localparam int STAB_TIME_NS = 20000;
    localparam int STAB_CYCLES  =
        (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAB_LINK_CYCLES =
        (STAB_TIME_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int STAB_W = 12;

    // divider phase seen at the controller edge
    localparam logic [1:0] PH_RISE   = 2'h3;  // this edge raises link clock
    localparam logic [1:0] PH_SLOT_A = 2'h2;  // command / first beat change
    localparam logic [1:0] PH_SLOT_B = 2'h0;  // second beat change
    localparam logic [1:0] PH_READY  = 2'h1;  // ready is raised here

    // controller edges after the command's link rise (timer value)
    localparam logic [3:0] T_BEAT0  = 4'h2;
    localparam logic [3:0] T_BEAT1  = 4'h4;
    localparam logic [3:0] T_WDONE  = 4'h6;
    localparam logic [3:0] T_RWORD0 = 4'hc;
    localparam logic [3:0] T_RWORD1 = 4'he;

    typedef enum logic [4:0] {
        ST_INIT  = 5'h01,
        ST_IDLE  = 5'h02,
        ST_CMD   = 5'h04,
        ST_WDATA = 5'h08,
        ST_RWAIT = 5'h10
    } dbsp_state_e;
endpackage

/* File: core/dbsp_link_if.sv */
// interface: the pins between memory controller and sram port
`timescale 1ns/1ps
interface dbsp_link_if;
    import dbsp_pkg::*;
    logic              link_clk;
    logic              load_strobe_n;
    logic              read_not_write;
    logic [ADDR_W-1:0] sync_address;
    logic [LANES-1:0]  byte_write_enable_n;
    logic              loop_bypass_n;
    logic              termination_select;
    logic [DATA_W-1:0] ctl_dq_out;
    logic              ctl_dq_oe;
    logic [DATA_W-1:0] dev_dq_out;
    logic              dev_dq_oe;
    logic              echo_clock;
    logic              echo_clock_n;
    logic              read_valid_out;
    logic [DATA_W-1:0] dq;

    // shared data bus level worked out from the two enables
    assign dq = dev_dq_oe ? dev_dq_out :
                ctl_dq_oe ? ctl_dq_out : '0;

    modport ctl (
        output link_clk, load_strobe_n, read_not_write, sync_address,
        output byte_write_enable_n, loop_bypass_n, termination_select,
        output ctl_dq_out, ctl_dq_oe,
        input  dq, echo_clock, echo_clock_n, read_valid_out
    );
    modport dev (
        input  link_clk, load_strobe_n, read_not_write, sync_address,
        input  byte_write_enable_n, loop_bypass_n, termination_select,
        input  dq,
        output dev_dq_out, dev_dq_oe, echo_clock, echo_clock_n,
        output read_valid_out
    );
endinterface

/* File: core/dbsp_controller.sv */
// module: memory controller end of the burst-of-two sram port
`timescale 1ns/1ps
module dbsp_controller
    import dbsp_pkg::*;
(
    dbsp_link_if.ctl          link,
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic         use_loop,
    input  wire logic         high_term,
    input  wire logic         req_valid,
    input  wire logic         req_write,
    input  wire [ADDR_W-1:0]  req_addr,
    input  wire [DATA_W-1:0]  req_wdata0,
    input  wire [DATA_W-1:0]  req_wdata1,
    input  wire [LANES-1:0]   req_be_n0,
    input  wire [LANES-1:0]   req_be_n1,
    output logic              req_ready,
    output logic              link_ready,
    output logic [DATA_W-1:0] rsp_rdata0,
    output logic [DATA_W-1:0] rsp_rdata1,
    output logic              rsp_valid
);
    // ======================================================
    // link clock divider
    logic [1:0] ph_reg;
    logic       k_reg;

    // clock edges and pin changes fall on alternate controller
    // edges, giving a quarter period of setup and hold
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ph_reg <= '0;
            k_reg  <= 1'b0;
        end
        else
        begin
            ph_reg <= ph_reg + 2'h1;
            k_reg  <= (ph_reg == PH_RISE) || (ph_reg == PH_SLOT_B);
        end
    end

    // ======================================================
    // state, stabilisation and request handling
    dbsp_state_e       state_reg;
    logic [STAB_W-1:0] stab_reg;
    logic [3:0]        t_reg;
    logic              loop_reg;
    logic              bypass_n_reg;
    logic              load_n_reg;
    logic              rnw_reg;
    logic              oe_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wd0_reg;
    logic [DATA_W-1:0] wd1_reg;
    logic [LANES-1:0]  be0_reg;
    logic [LANES-1:0]  be1_reg;
    logic [DATA_W-1:0] dout_reg;
    logic [LANES-1:0]  bout_reg;
    logic              take;

    assign take = req_valid && req_ready && (ph_reg == PH_SLOT_A);

    // the loop is asked for only when the link is fast enough;
    // any change restarts the full settle wait
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            loop_reg     <= 1'b0;
            bypass_n_reg <= 1'b0;
        end
        else
        begin
            loop_reg     <= use_loop;
            bypass_n_reg <= use_loop && LOOP_FREQ_OK;  // R2 R4
        end
    end

    // timer counts edges since the command's link rise
    always_ff @(posedge clock)
    begin
        if (reset || (state_reg == ST_CMD && ph_reg == PH_RISE))
            t_reg <= '0;
        else
            t_reg <= t_reg + 4'h1;
    end

    always_ff @(posedge clock)
    begin
        if (reset || (loop_reg != use_loop))
        begin
            state_reg <= ST_INIT;  // R5
            stab_reg  <= '0;
        end
        else
        begin
            case (state_reg)
            ST_INIT:
                if (stab_reg == STAB_W'(STAB_CYCLES - 1))
                    state_reg <= ST_IDLE;  // R1 R3
                else
                    stab_reg <= stab_reg + STAB_W'(1);
            ST_IDLE:
                if (take)
                    state_reg <= ST_CMD;
            ST_CMD:
                if (ph_reg == PH_RISE)
                    state_reg <= rnw_reg ? ST_RWAIT : ST_WDATA;
            ST_WDATA:
                if (t_reg == T_WDONE)
                    state_reg <= ST_IDLE;
            ST_RWAIT:
                if (t_reg == T_RWORD1)
                    state_reg <= ST_IDLE;
            default:
                state_reg <= ST_INIT;
            endcase
        end
    end

    // command pins change a quarter link period ahead of the rise
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            load_n_reg <= 1'b1;
            rnw_reg    <= 1'b1;
            addr_reg   <= '0;
            wd0_reg    <= '0;
            wd1_reg    <= '0;
            be0_reg    <= '1;
            be1_reg    <= '1;
        end
        else if (take)
        begin
            load_n_reg <= 1'b0;  // R16
            rnw_reg    <= !req_write;
            addr_reg   <= req_addr;
            wd0_reg    <= req_wdata0;
            wd1_reg    <= req_wdata1;
            be0_reg    <= req_be_n0;
            be1_reg    <= req_be_n1;
        end
        else if (state_reg != ST_CMD)
            load_n_reg <= 1'b1;
    end

    // write beats: first held over the next rise, second over the fall
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            oe_reg   <= 1'b0;
            dout_reg <= '0;
            bout_reg <= '1;
        end
        else if (state_reg == ST_WDATA && t_reg == T_BEAT0)
        begin
            oe_reg   <= 1'b1;  // R14
            dout_reg <= wd0_reg;
            bout_reg <= be0_reg;  // R21
        end
        else if (state_reg == ST_WDATA && t_reg == T_BEAT1)
        begin
            dout_reg <= wd1_reg;
            bout_reg <= be1_reg;
        end
        else if (state_reg == ST_WDATA && t_reg == T_WDONE)
        begin
            oe_reg   <= 1'b0;
            bout_reg <= '1;
        end
    end

    // one request at a time keeps the shared bus free of turnarounds
    always_ff @(posedge clock)
    begin
        if (reset)
            req_ready <= 1'b0;
        else
            req_ready <= (state_reg == ST_IDLE) && (ph_reg == PH_READY);
    end

    // ======================================================
    // read capture through two flops
    logic [DATA_W-1:0] dq_s1_reg;
    logic [DATA_W-1:0] dq_s2_reg;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            dq_s1_reg  <= '0;
            dq_s2_reg  <= '0;
            rsp_rdata0 <= '0;
            rsp_rdata1 <= '0;
            rsp_valid  <= 1'b0;
        end
        else
        begin
            dq_s1_reg <= link.dq;
            dq_s2_reg <= dq_s1_reg;
            rsp_valid <= (state_reg == ST_RWAIT) && (t_reg == T_RWORD1);
            if (state_reg == ST_RWAIT && t_reg == T_RWORD0)
                rsp_rdata0 <= dq_s2_reg;  // R15
            if (state_reg == ST_RWAIT && t_reg == T_RWORD1)
                rsp_rdata1 <= dq_s2_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            link_ready <= 1'b0;
        else
            link_ready <= (state_reg != ST_INIT);
    end

    // ======================================================
    // pin drive; a stopped link clock parks low
    assign link.link_clk            = k_reg;  // R19
    assign link.load_strobe_n       = load_n_reg;
    assign link.read_not_write      = rnw_reg;
    assign link.sync_address        = addr_reg;
    assign link.byte_write_enable_n = bout_reg;
    assign link.loop_bypass_n       = bypass_n_reg;
    assign link.termination_select  = high_term;
    assign link.ctl_dq_out          = dout_reg;
    assign link.ctl_dq_oe           = oe_reg;
endmodule

/* File: tb/dbsp_link_asserts.sv */
// checker: read valid, data enable and termination timing on the link
`timescale 1ns/1ps
module dbsp_link_asserts (
    input wire logic link_clk,
    input wire logic reset,
    input wire logic load_strobe_n,
    input wire logic read_not_write,
    input wire logic dev_dq_oe,
    input wire logic read_valid_out,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    input wire logic term_enable
);
    // ==========================================================
    // helper logic
    // read command as the device samples it at a link rise
    wire  cmd_rd = !load_strobe_n && read_not_write;
    logic seen_rd;

    // remembers a loaded read, so power-up driving is caught
    always_ff @(posedge link_clk)
    begin
        if (reset)
            seen_rd <= 1'h0;
        else if (cmd_rd)
            seen_rd <= 1'h1;
    end

    default disable iff (reset);

    // ==========================================================
    // assertions; the controller is serial, so reads never overlap
    AST_VALID_RISE: assert property (@(posedge link_clk)
        $rose(read_valid_out) |-> $past(cmd_rd, 3))
        else $error("read valid rose without a read three rises back");
    AST_VALID_FALL: assert property (@(posedge link_clk)
        cmd_rd ##1 !cmd_rd |-> ##3 !read_valid_out)
        else $error("read valid held past the burst");
    AST_VALID_LEADS: assert property (@(negedge link_clk)
        $rose(dev_dq_oe) |-> $past(read_valid_out) && !read_valid_out)
        else $error("read valid not half a cycle ahead of data");
    AST_ECHO: assert property (@(negedge link_clk)
        echo_clock && !echo_clock_n)
        else $error("echo clocks not aligned to the link clock");
    AST_TERM_OFF: assert property (@(posedge link_clk)
        cmd_rd |-> ##2 term_enable ##1 !term_enable)
        else $error("termination not off at read plus two");
    AST_TERM_ON: assert property (@(posedge link_clk)
        cmd_rd |-> ##3 !term_enable ##1 term_enable)
        else $error("termination back on at the wrong time");
    AST_TERM_RX: assert property (@(posedge link_clk)
        !load_strobe_n && !read_not_write |=> term_enable ##1 term_enable)
        else $error("termination not on while receiving write data");
    AST_POWERUP: assert property (@(posedge link_clk)
        dev_dq_oe |-> seen_rd)
        else $error("data bus driven before any read");
    AST_OE_CAUSE: assert property (@(posedge link_clk)
        $rose(dev_dq_oe) |-> $past(cmd_rd, 3))
        else $error("data driven without a read command");
    AST_BURST2: assert property (@(negedge link_clk)
        $rose(dev_dq_oe) |=> !dev_dq_oe)
        else $error("read burst longer than two words");

    // main scenarios reached
    COV_READ: cover property (@(posedge link_clk) cmd_rd);
    COV_WRITE: cover property (@(posedge link_clk)
        !load_strobe_n && !read_not_write);
    COV_TERM: cover property (@(negedge link_clk) $rose(term_enable));
endmodule

/* File: tb/ddr_burst2_sram_port_test.sv */
// testbench: controller and device joined, random bursts checked
`timescale 1ns/1ps
module ddr_burst2_sram_port_test;
    import dbsp_pkg::*;
    logic              clock      = 1'h0;
    logic              reset      = 1'h1;
    logic              dev_reset  = 1'h1;
    logic              high_term  = 1'h1;
    logic              use_loop   = 1'h0;
    logic              req_valid  = 1'h0;
    logic              req_write  = 1'h0;
    logic [ADDR_W-1:0] req_addr   = 20'h0_0000;
    logic [DATA_W-1:0] req_wdata0 = 36'h0_0000_0000;
    logic [DATA_W-1:0] req_wdata1 = 36'h0_0000_0000;
    logic [LANES-1:0]  req_be_n0  = 4'hf;
    logic [LANES-1:0]  req_be_n1  = 4'hf;
    logic              req_ready;
    logic              link_ready;
    logic              rsp_valid;
    logic              loop_ready;
    logic              term_enable;
    logic              term_high_range;
    logic [DATA_W-1:0] rsp_rdata0;
    logic [DATA_W-1:0] rsp_rdata1;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    int                n_mismatch = 0;
    int                compares   = 0;

    // ==========================================================
    // clock and the two ends
    always #12.5 clock = ~clock;

    dbsp_link_if dbsp_link_if_inst ();
    dbsp_controller dbsp_controller_inst (
        .link(dbsp_link_if_inst), .clock(clock), .reset(reset),
        .use_loop(use_loop), .high_term(high_term), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr),
        .req_wdata0(req_wdata0), .req_wdata1(req_wdata1),
        .req_be_n0(req_be_n0), .req_be_n1(req_be_n1),
        .req_ready(req_ready), .link_ready(link_ready),
        .rsp_rdata0(rsp_rdata0), .rsp_rdata1(rsp_rdata1),
        .rsp_valid(rsp_valid));
    dbsp_device dbsp_device_inst (
        .link(dbsp_link_if_inst), .reset(dev_reset),
        .loop_ready(loop_ready), .term_enable(term_enable),
        .term_high_range(term_high_range));
    dbsp_link_asserts dbsp_link_asserts_inst (
        .link_clk(dbsp_link_if_inst.link_clk), .reset(dev_reset),
        .load_strobe_n(dbsp_link_if_inst.load_strobe_n),
        .read_not_write(dbsp_link_if_inst.read_not_write),
        .dev_dq_oe(dbsp_link_if_inst.dev_dq_oe),
        .read_valid_out(dbsp_link_if_inst.read_valid_out),
        .echo_clock(dbsp_link_if_inst.echo_clock),
        .echo_clock_n(dbsp_link_if_inst.echo_clock_n),
        .term_enable(term_enable));

    // ==========================================================
    // comparison, model and closing
    task automatic check_word(input logic [DATA_W-1:0] got,
                              input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // lanes with a low enable take the new data, others keep old
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
        input logic [LANES-1:0] be_n);
        for (int l = 0; l < LANES; l++)
            if (!be_n[l])
                old[l*LANE_W +: LANE_W] = nw[l*LANE_W +: LANE_W];
        return old;
    endfunction

    // one request, held until taken; a read waits for its answer
    task automatic run_op(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [LANES-1:0] b0,
                          input logic [LANES-1:0] b1);
        logic [DATA_W-1:0] w0;
        logic [DATA_W-1:0] w1;
        int                n;
        w0 = DATA_W'({$urandom, $urandom});
        w1 = DATA_W'({$urandom, $urandom});
        n = 0;
        @(posedge clock);
        req_valid  <= 1'h1;
        req_write  <= wr;
        req_addr   <= a;
        req_wdata0 <= w0;
        req_wdata1 <= w1;
        req_be_n0  <= b0;
        req_be_n1  <= b1;
        do @(negedge clock); while (req_ready !== 1'h1 && ++n < 200);
        @(posedge clock);
        req_valid <= 1'h0;
        if (wr)
        begin
            mem[a] = merge(mem[a], w0, b0);
            mem[a ^ BURST_FLIP] = merge(mem[a ^ BURST_FLIP], w1, b1);
        end
        else
        begin
            do @(negedge clock); while (rsp_valid !== 1'h1 && ++n < 260);
            check_word(rsp_rdata0, mem[a]);
            check_word(rsp_rdata1, mem[a ^ BURST_FLIP]);
        end
        if (n >= 200)
            n_mismatch++;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        logic [ADDR_W-1:0] a;
        int                n;
        void'($urandom(47));
        n = 0;
        repeat (20) @(posedge clock);
        reset <= 1'h0;
        repeat (20) @(posedge clock);
        dev_reset <= 1'h0;
        do @(negedge clock); while (link_ready !== 1'h1 && ++n < 1200);
        check_word(DATA_W'(link_ready), 36'h0_0000_0001);
        $display("test init done");
        for (int i = 0; i < 30; i++)
        begin
            a = ADDR_W'($urandom);
            run_op(1'h1, a, 4'h0, 4'h0);
            run_op(1'h1, a, (i == 0) ? 4'hf : (i == 1) ? 4'h0 :
                   LANES'($urandom), (i == 0) ? 4'h0 : LANES'($urandom));
            run_op(1'h0, a ^ ADDR_W'(i % 2), 4'hf, 4'hf);
            check_word(DATA_W'(term_high_range), DATA_W'(high_term));
            @(posedge clock) high_term <= 1'($urandom);
        end
        $display("test bursts done");
        check_word(DATA_W'(loop_ready), 36'h0_0000_0001);
        $display("test loop done");
        // asking for the loop restarts the settle wait; a slow link
        // must still keep the loop bypassed
        @(posedge clock) use_loop <= 1'h1;
        repeat (4) @(posedge clock);
        check_word(DATA_W'(link_ready), 36'h0_0000_0000);
        check_word(DATA_W'(dbsp_link_if_inst.loop_bypass_n), '0);
        do @(negedge clock); while (link_ready !== 1'h1 && ++n < 2400);
        check_word(DATA_W'(link_ready), 36'h0_0000_0001);
        $display("test restart done");
        results();
    end

    // watchdog: the run needs a few thousand cycles at most
    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        results();
    end
endmodule
